// *** bench/dual_array_dev_model.sv ***
/*
  Behavioural model of the combined flash and EEPROM part.
  Assumes a host whose pins change only on the rising clock edge.
*/
`timescale 1ns/1ps
module dual_array_dev_model
  import dual_array_pkg::*;
#(
  parameter int         LOAD_WIN   = 300,
  parameter int         BUSY_CYC   = 200,
  parameter logic [7:0] MAKER_CODE = 8'h3C, // Arbitrary value
  parameter logic [7:0] PART_CODE  = 8'h5A  // Arbitrary value
)
(
  input  wire logic              clock,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] addrPins,
  input  wire logic [DATA_W-1:0] dataOut,
  input  wire logic              flashSelectN,
  input  wire logic              eepromSelectN,
  input  wire logic              writeEnableN,
  input  wire logic              outputEnableN,
  output logic      [DATA_W-1:0] readData
);
  logic [7:0]  flashMem [int];
  logic [7:0]  eepromMem [int];
  logic [1:0]  seqReg;
  logic        armedReg, loadReg, idReg, eeTgtReg, lastBitReg, weReg, selEReg, selFReg;
  logic [18:0] addrReg;
  logic [7:0]  dataReg;
  logic [7:0]  lastOut = 8'h00;
  int          loadCnt, busyCnt, rdIdx;
  wire         strobeEnd = !weReg && writeEnableN && (selEReg || selFReg);

  always @(posedge clock) begin
    weReg <= writeEnableN;
    if (!outputEnableN) lastOut <= readData;
    if (!writeEnableN) begin
      addrReg <= addrPins;
      dataReg <= dataOut;
      selFReg <= !flashSelectN;
      selEReg <= !eepromSelectN;
    end
    if (srst) begin
      seqReg <= 2'h0;
      armedReg <= 1'b0;
      loadReg <= 1'b0;
      idReg <= 1'b0;
      busyCnt <= 0;
    end else begin
      if (busyCnt > 0) busyCnt <= busyCnt - 1;
      loadCnt <= loadCnt + 1;
      if (loadReg && loadCnt >= LOAD_WIN) begin
        loadReg <= 1'b0;
        busyCnt <= BUSY_CYC;
      end
      if (strobeEnd) begin
        if ((loadReg || armedReg) && selEReg == eeTgtReg) begin
          if (selEReg) eepromMem[int'(addrReg[14:0])] = dataReg;
          else flashMem[int'(addrReg)] = dataReg;
          loadReg <= 1'b1;
          armedReg <= 1'b0;
          loadCnt <= 0;
          lastBitReg <= dataReg[7];
        end else if (seqReg == 2'h0 && dataReg == CMD_BYTE_A && addrReg[14:0] == CMD_ADDR_A)
          seqReg <= 2'h1;
        else if (seqReg == 2'h1 && dataReg == CMD_BYTE_B && addrReg[14:0] == CMD_ADDR_B)
          seqReg <= 2'h2;
        else if (seqReg == 2'h2 && addrReg[14:0] == CMD_ADDR_A) begin
          seqReg <= 2'h0;
          armedReg <= dataReg == CMD_WRITE;
          eeTgtReg <= selEReg;
          if (dataReg == CMD_ID_IN) idReg <= 1'b1;
          if (dataReg == CMD_ID_OUT) idReg <= 1'b0;
        end else seqReg <= 2'h0;
      end
    end
  end

  always @* begin
    rdIdx = eepromSelectN ? int'(addrPins) : int'(addrPins[14:0]);
    if (outputEnableN || flashSelectN == eepromSelectN) readData = ~lastOut;
    else if (idReg && !flashSelectN) readData = addrPins[0] ? PART_CODE : MAKER_CODE;
    else if (busyCnt > 0 && !eepromSelectN == eeTgtReg)
      readData = {~lastBitReg, 7'h00};
    else if (!eepromSelectN)
      readData = eepromMem.exists(rdIdx) ? eepromMem[rdIdx] : 8'(rdIdx) ^ 8'hA5;
    else readData = flashMem.exists(rdIdx) ? flashMem[rdIdx] : 8'(rdIdx) ^ 8'hA5;
  end
endmodule : dual_array_dev_model

// *** bench/dual_array_host_properties.sv ***
/*
  Checker on the pins and status ports of the flash and EEPROM host.
  Assumes a bind onto dual_array_host; one clock, synchronous reset.
*/
`timescale 1ns/1ps
module dual_array_host_checker
  import dual_array_pkg::*;
(
  input wire logic              clock,
  input wire logic              srst,
  input wire logic              cmdValid,
  input wire op_t               cmdOp,
  input wire logic              cmdEeprom,
  input wire logic              cmdReady,
  input wire logic              rspError,
  input wire logic              flashBusy,
  input wire logic              eepromBusy,
  input wire logic              loadOpen,
  input wire logic              idMode,
  input wire logic [ADDR_W-1:0] addrPins,
  input wire logic [DATA_W-1:0] dataOut,
  input wire logic              dataOe,
  input wire logic              flashSelectN,
  input wire logic              eepromSelectN,
  input wire logic              writeEnableN,
  input wire logic              outputEnableN
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  wire take = cmdValid && cmdReady;

  property p_sel_excl; !(!flashSelectN && !eepromSelectN); endproperty
  a_sel_excl: assert property (p_sel_excl) else $error("both selects low");
  property p_ee_addr; !eepromSelectN |-> addrPins[18:15] == 4'h0; endproperty
  a_ee_addr: assert property (p_ee_addr) else $error("eeprom upper address set");
  property p_oe_drive; !outputEnableN |-> !dataOe; endproperty
  a_oe_drive: assert property (p_oe_drive) else $error("data driven in read");
  property p_wr_seq;
    take && cmdOp == OP_WRITE_START ##1 !rspError |-> ##[1:60]
      ($fell(writeEnableN) && dataOut == CMD_BYTE_A && addrPins[14:0] == CMD_ADDR_A);
  endproperty
  a_wr_seq: assert property (p_wr_seq) else $error("write without unlock");
  property p_id_cmd;
    take && cmdOp == OP_ID_ENTRY ##1 !rspError |-> ##[1:300]
      ($fell(writeEnableN) && dataOut == CMD_ID_IN && addrPins[14:0] == CMD_ADDR_A);
  endproperty
  a_id_cmd: assert property (p_id_cmd) else $error("id entry byte missing");
  property p_id_reset; $fell(srst) |-> !idMode && !loadOpen; endproperty
  a_id_reset: assert property (p_id_reset) else $error("id mode kept over reset");
  property p_id_exit;
    take && cmdOp == OP_ID_EXIT ##1 !rspError |-> ##[1:400] !idMode;
  endproperty
  a_id_exit: assert property (p_id_exit) else $error("id mode not left");
  property p_expire; $fell(loadOpen) |-> flashBusy || eepromBusy; endproperty
  a_expire: assert property (p_expire) else $error("window closed without busy");
  property p_id_read;
    idMode && !flashSelectN && !outputEnableN |-> eepromSelectN && addrPins[18:1] == 18'h00000;
  endproperty
  a_id_read: assert property (p_id_read) else $error("bad id read pins");
  property p_conc;
    take && cmdOp == OP_READ && !cmdEeprom && eepromBusy && !loadOpen && !idMode |=> !rspError;
  endproperty
  a_conc: assert property (p_conc) else $error("flash read refused");
  c_id: cover property (take && cmdOp == OP_ID_ENTRY);
  c_conc: cover property (take && cmdOp == OP_READ && eepromBusy);
  c_load: cover property (take && cmdOp == OP_READ && loadOpen);
endmodule : dual_array_host_checker

bind dual_array_host dual_array_host_checker i_dual_array_host_checker (.*);

// *** bench/dual_array_host_tb_top.sv ***
/*
  Self-checking bench for the flash and EEPROM host controller.
  Assumes the device model and checker files are compiled first.
*/
`timescale 1ns/1ps
module dual_array_host_tb_top;
  import dual_array_pkg::*;
  localparam logic [7:0] MAKER = 8'h3C;
  localparam logic [7:0] PART  = 8'h5A;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        cmdValid = 1'b0;
  logic        cmdEeprom = 1'b0;
  op_t         cmdOp = OP_READ;
  logic [18:0] cmdAddr = 19'h00000;
  logic [7:0]  cmdData = 8'h00;
  logic        cmdReady, rspValid, rspError, flashBusy, eepromBusy, loadOpen, idMode;
  logic        dataOe, flashSelectN, eepromSelectN, writeEnableN, outputEnableN, erv, curEe;
  logic [18:0] addrPins;
  logic [7:0]  rspData, dataOut, dataIn, rdv;
  int          err_total = 0;
  int          num_checks = 0;
  wire         curBusy = curEe ? eepromBusy : flashBusy;

  always #2.5 clock = ~clock;

  dual_array_host #(.BYTE_LOAD_WINDOW_CYC(300), .FLASH_WRITE_CYC(500)) i_dual_array_host (.*);

  dual_array_dev_model #(.LOAD_WIN(300), .MAKER_CODE(MAKER), .PART_CODE(PART))
  i_dual_array_dev_model (.*, .readData(dataIn));

  function automatic logic [7:0] pat(input logic [18:0] a);
    return a[7:0] ^ 8'hA5;
  endfunction : pat

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic cmd(input op_t op, input logic ee, input logic [18:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge clock);
    cmdValid <= 1'b1;
    cmdOp <= op;
    cmdEeprom <= ee;
    cmdAddr <= a;
    cmdData <= d;
    do begin @(posedge clock); n++; end while (cmdReady !== 1'b1 && n < 5000);
    cmdValid <= 1'b0;
    do begin @(posedge clock); n++; end while (rspValid !== 1'b1 && n < 5000);
    if (n >= 5000) chk("response", 8'h01, 8'h00);
    rdv = rspData;
    erv = rspError;
  endtask : cmd

  task automatic pageWrite(input logic ee, input int n);
    logic [18:0] a;
    logic [18:0] fa;
    logic [7:0]  d [4];
    int          k;
    curEe = ee;
    a = 19'($urandom) & 19'h7FFF0;
    fa = 19'($urandom);
    for (k = 0; k < n; k++) d[k] = 8'($urandom);
    cmd(OP_WRITE_START, ee, a, d[0]);
    chk("start taken", 8'h00, 8'(erv));
    for (k = 1; k < n; k++) begin
      if (ee) cmd(OP_READ, 1'b0, fa, 8'h00);
      if (ee) chk("flash read in window", pat(fa), rdv);
      cmd(OP_LOAD, ee, a + 19'(k), d[k]);
      chk("load taken", 8'h00, 8'(erv));
    end
    cmd(OP_LOAD, !ee, a, 8'h00);
    chk("other array load", 8'h01, 8'(erv));
    k = 0;
    while (curBusy !== 1'b1 && k < 1000) begin @(posedge clock); k++; end
    chk("busy after window", 8'h01, 8'(curBusy));
    cmd(OP_WRITE_START, ee, a, d[0]);
    chk("start while busy", 8'h01, 8'(erv));
    if (ee) cmd(OP_READ, 1'b0, fa, 8'h00);
    if (ee) chk("flash read while busy", pat(fa), rdv);
    cmd(OP_POLL, ee, a, 8'h00);
    chk("poll bit busy", {7'h00, ~d[n-1][7]}, 8'(rdv[7]));
    k = 0;
    while (curBusy === 1'b1 && k < 20) begin cmd(OP_POLL, ee, a, 8'h00); k++; end
    chk("busy cleared", 8'h00, 8'(curBusy));
    for (k = 0; k < n; k++) begin
      cmd(OP_READ, ee, (a + 19'(k)) ^ (ee ? 19'h78000 : 19'h00000), 8'h00);
      chk("read back", d[k], rdv);
    end
  endtask : pageWrite

  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  initial begin
    #300000;
    err_total++;
    give_verdict();
  end

  initial begin
    void'($urandom(67436));
    repeat (2) @(posedge clock);
    chk("ready in reset", 8'h00, 8'(cmdReady));
    chk("id in reset", 8'h00, 8'(idMode));
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    repeat (3) @(posedge clock);
    cmd(OP_LOAD, 1'b1, 19'h00000, 8'h00);
    chk("load without start", 8'h01, 8'(erv));
    cmd(OP_ID_READ, 1'b0, 19'h00000, 8'h00);
    chk("id read outside", 8'h01, 8'(erv));
    cmd(OP_ID_ENTRY, 1'b0, 19'h00000, 8'h00);
    chk("id entered", 8'h01, 8'(idMode));
    cmd(OP_ID_READ, 1'b0, 19'h00000, 8'h00);
    chk("maker code", MAKER, rdv);
    cmd(OP_ID_READ, 1'b0, 19'h00001, 8'h00);
    chk("part code", PART, rdv);
    cmd(OP_ID_EXIT, 1'b0, 19'h00000, 8'h00);
    chk("id left", 8'h00, 8'(idMode));
    cmd(OP_READ, 1'b0, 19'h00001, 8'h00);
    chk("normal read", pat(19'h00001), rdv);
    pageWrite(1'b1, 3);
    pageWrite(1'b0, 1);
    repeat (4) pageWrite(1'($urandom), 1 + int'($urandom % 3));
    give_verdict();
  end
endmodule : dual_array_host_tb_top

// *** hw/bus_cycle.sv ***
/*
  One bus cycle on the shared pins: a read or a write strobe to one array.
  Assumes one cycle at a time and data pins synchronous to the clock.
*/
`timescale 1ns/1ps
module bus_cycle
  import dual_array_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              srst,
  input  wire logic              start,
  input  wire logic              isWrite,
  input  wire logic              toEeprom,
  input  wire logic [ADDR_W-1:0] addrIn,
  input  wire logic [DATA_W-1:0] dataIn,
  output logic                   done,
  output logic [DATA_W-1:0]      rdData,
  output logic [ADDR_W-1:0]      addrPins,
  output logic [DATA_W-1:0]      dataOut,
  output logic                   dataOe,
  input  wire logic [DATA_W-1:0] dataPinsIn,
  output logic                   flashSelectN,
  output logic                   eepromSelectN,
  output logic                   writeEnableN,
  output logic                   outputEnableN
);

  typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_STROBE, PH_RECOVER} phase_t;

  localparam logic [7:0] STROBE_END = 8'(STROBE_CYC - 1);
  localparam logic [7:0] ACCESS_END = 8'(ACCESS_CYC);
  localparam logic [7:0] HOLD_END   = 8'(DATA_HOLD_CYC);
  localparam logic [7:0] HIGH_END   = 8'(HIGH_CYC - 1);

  phase_t              phase_reg, phase_next;
  logic [7:0]          cnt_reg, cnt_next;
  logic                write_reg, write_next;
  logic                ee_reg, ee_next;
  logic                done_reg, done_next;
  logic [DATA_W-1:0]   rd_reg, rd_next;
  logic [ADDR_W-1:0]   addr_reg, addr_next;
  logic [DATA_W-1:0]   dout_reg, dout_next;
  logic                doe_reg, doe_next;
  logic                fsel_reg, fsel_next;
  logic                esel_reg, esel_next;
  logic                we_reg, we_next;
  logic                oe_reg, oe_next;

  always_comb begin
    phase_next = phase_reg;
    cnt_next   = cnt_reg;
    write_next = write_reg;
    ee_next    = ee_reg;
    done_next  = 1'b0;
    rd_next    = rd_reg;
    addr_next  = addr_reg;
    dout_next  = dout_reg;
    doe_next   = doe_reg;
    fsel_next  = fsel_reg;
    esel_next  = esel_reg;
    we_next    = we_reg;
    oe_next    = oe_reg;
    case (phase_reg)
      PH_IDLE: begin
        if (start) begin
          addr_next  = addrIn;
          dout_next  = dataIn;
          doe_next   = isWrite;
          write_next = isWrite;
          ee_next    = toEeprom;
          phase_next = PH_SETUP;
        end
      end
      PH_SETUP: begin
        // Only one select ever goes low
        fsel_next  = ee_reg;
        esel_next  = !ee_reg;
        we_next    = !write_reg;
        oe_next    = write_reg;
        cnt_next   = 8'h00;
        phase_next = PH_STROBE;
      end
      PH_STROBE: begin
        cnt_next = cnt_reg + 8'h01;
        if ((write_reg && cnt_reg == STROBE_END) || (!write_reg && cnt_reg == ACCESS_END)) begin
          if (!write_reg) begin
            rd_next = dataPinsIn;
          end
          fsel_next  = 1'b1;
          esel_next  = 1'b1;
          we_next    = 1'b1;
          oe_next    = 1'b1;
          cnt_next   = 8'h00;
          phase_next = PH_RECOVER;
        end
      end
      PH_RECOVER: begin
        // Selects high before next cycle
        cnt_next = cnt_reg + 8'h01;
        if (cnt_reg == HOLD_END) begin
          doe_next = 1'b0;
        end
        if (cnt_reg == HIGH_END) begin
          done_next  = 1'b1;
          phase_next = PH_IDLE;
        end
      end
      default: begin
        phase_next = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      phase_reg <= PH_IDLE;
      cnt_reg   <= 8'h00;
      write_reg <= 1'b0;
      ee_reg    <= 1'b0;
      done_reg  <= 1'b0;
      rd_reg    <= '0;
      addr_reg  <= '0;
      dout_reg  <= '0;
      doe_reg   <= 1'b0;
      fsel_reg  <= 1'b1;
      esel_reg  <= 1'b1;
      we_reg    <= 1'b1;
      oe_reg    <= 1'b1;
    end else begin
      phase_reg <= phase_next;
      cnt_reg   <= cnt_next;
      write_reg <= write_next;
      ee_reg    <= ee_next;
      done_reg  <= done_next;
      rd_reg    <= rd_next;
      addr_reg  <= addr_next;
      dout_reg  <= dout_next;
      doe_reg   <= doe_next;
      fsel_reg  <= fsel_next;
      esel_reg  <= esel_next;
      we_reg    <= we_next;
      oe_reg    <= oe_next;
    end
  end

  assign done          = done_reg;
  assign rdData        = rd_reg;
  assign addrPins      = addr_reg;
  assign dataOut       = dout_reg;
  assign dataOe        = doe_reg;
  assign flashSelectN  = fsel_reg;
  assign eepromSelectN = esel_reg;
  assign writeEnableN  = we_reg;
  assign outputEnableN = oe_reg;

endmodule : bus_cycle

// *** hw/dual_array_host.sv ***
/*
  Host controller for a flash plus EEPROM part on a shared byte bus.
  Assumes a user that waits for cmdReady and a self-timed device.
*/
`timescale 1ns/1ps
module dual_array_host
  import dual_array_pkg::*;
#(
  parameter int BYTE_LOAD_WINDOW_CYC = WINDOW_CYC,
  parameter int FLASH_WRITE_CYC      = WRITE_CYC
)
(
  input  wire logic              clock,
  input  wire logic              srst,
  input  wire logic              cmdValid,
  input  wire op_t               cmdOp,
  input  wire logic              cmdEeprom,
  input  wire logic [ADDR_W-1:0] cmdAddr,
  input  wire logic [DATA_W-1:0] cmdData,
  output logic                   cmdReady,
  output logic                   rspValid,
  output logic [DATA_W-1:0]      rspData,
  output logic                   rspError,
  output logic                   flashBusy,
  output logic                   eepromBusy,
  output logic                   loadOpen,
  output logic                   idMode,
  output logic [ADDR_W-1:0]      addrPins,
  output logic [DATA_W-1:0]      dataOut,
  output logic                   dataOe,
  input  wire logic [DATA_W-1:0] dataIn,
  output logic                   flashSelectN,
  output logic                   eepromSelectN,
  output logic                   writeEnableN,
  output logic                   outputEnableN
);

  localparam int TW = $clog2(FLASH_WRITE_CYC + BYTE_LOAD_WINDOW_CYC + 1);
  localparam logic [TW-1:0] LOAD_LIMIT = TW'(BYTE_LOAD_WINDOW_CYC - LOAD_MARGIN_CYC);
  localparam logic [TW-1:0] WINDOW_END = TW'(BYTE_LOAD_WINDOW_CYC);
  localparam logic [TW-1:0] WRITE_END  = TW'(FLASH_WRITE_CYC);

  typedef enum logic [2:0] {ST_IDLE, ST_SEQ, ST_SEQ_WAIT, ST_USER, ST_USER_WAIT} state_t;

  state_t              state_reg, state_next;
  logic [1:0]          seq_reg, seq_next;
  op_t                 op_reg, op_next;
  logic                ee_reg, ee_next;
  logic [ADDR_W-1:0]   addr_reg, addr_next;
  logic [DATA_W-1:0]   data_reg, data_next;
  logic                ready_reg, ready_next;
  logic                rspv_reg, rspv_next;
  logic [DATA_W-1:0]   rspd_reg, rspd_next;
  logic                rspe_reg, rspe_next;
  logic                start_reg, start_next;
  logic                ewr_reg, ewr_next;
  logic                eee_reg, eee_next;
  logic [ADDR_W-1:0]   eaddr_reg, eaddr_next;
  logic [DATA_W-1:0]   edata_reg, edata_next;

  logic                open_reg, open_next;
  logic                lee_reg, lee_next;
  logic [TW-1:0]       ltim_reg, ltim_next;
  logic [1:0]          busy_reg, busy_next;
  logic [TW-1:0]       btim_reg [2], btim_next [2];
  logic [ADDR_W-1:0]   laddr_reg [2], laddr_next [2];
  logic [1:0]          lbit_reg, lbit_next;
  logic                id_reg, id_next;

  logic                engDone;
  logic [DATA_W-1:0]   engRd;
  logic                take;
  logic                legal;
  logic                evLoad;
  logic                evPoll;
  logic                evIdIn;
  logic                evIdOut;
  logic                arrIdx;

  assign arrIdx = cmdEeprom;

  // Command legality
  always_comb begin
    legal = 1'b0;
    case (cmdOp)
      OP_WRITE_START: legal = !busy_reg[arrIdx] && !open_reg && !id_reg;
      OP_LOAD:        legal = open_reg && (lee_reg == cmdEeprom)
                              && (ltim_reg < LOAD_LIMIT);
      OP_READ:        legal = !id_reg && !(open_reg && (lee_reg == cmdEeprom));
      OP_POLL:        legal = !id_reg && !(open_reg && (lee_reg == cmdEeprom));
      OP_ID_ENTRY:    legal = !id_reg && !open_reg;
      OP_ID_EXIT:     legal = id_reg;
      OP_ID_READ:     legal = id_reg;
      default:        legal = 1'b0;
    endcase
  end

  assign take = (state_reg == ST_IDLE) && ready_reg && cmdValid;

  // Command sequencer
  always_comb begin
    state_next = state_reg;
    seq_next   = seq_reg;
    op_next    = op_reg;
    ee_next    = ee_reg;
    addr_next  = addr_reg;
    data_next  = data_reg;
    rspv_next  = 1'b0;
    rspd_next  = rspd_reg;
    rspe_next  = 1'b0;
    start_next = 1'b0;
    ewr_next   = ewr_reg;
    eee_next   = eee_reg;
    eaddr_next = eaddr_reg;
    edata_next = edata_reg;
    evLoad     = 1'b0;
    evPoll     = 1'b0;
    evIdIn     = 1'b0;
    evIdOut    = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (take) begin
          op_next = cmdOp;
          ee_next = cmdEeprom;
          addr_next = cmdEeprom ? {4'h0, cmdAddr[CMD_ADDR_W-1:0]} : cmdAddr;
          data_next = cmdData;
          seq_next  = 2'd0;
          if (!legal) begin
            rspv_next = 1'b1;
            rspe_next = 1'b1;
          end else if (cmdOp == OP_WRITE_START || cmdOp == OP_ID_ENTRY
                       || cmdOp == OP_ID_EXIT) begin
            state_next = ST_SEQ;
          end else begin
            state_next = ST_USER;
          end
        end
      end
      ST_SEQ: begin
        // Id commands use flash select
        start_next = 1'b1;
        ewr_next   = 1'b1;
        eee_next   = (op_reg == OP_WRITE_START) && ee_reg;
        eaddr_next = {4'h0, (seq_reg == 2'd1) ? CMD_ADDR_B : CMD_ADDR_A};
        case (seq_reg)
          2'd0:    edata_next = CMD_BYTE_A;
          2'd1:    edata_next = CMD_BYTE_B;
          default: edata_next = (op_reg == OP_WRITE_START) ? CMD_WRITE :
                                (op_reg == OP_ID_ENTRY) ? CMD_ID_IN : CMD_ID_OUT;
        endcase
        state_next = ST_SEQ_WAIT;
      end
      ST_SEQ_WAIT: begin
        if (engDone) begin
          if (seq_reg != 2'd2) begin
            seq_next   = seq_reg + 2'd1;
            state_next = ST_SEQ;
          end else if (op_reg == OP_WRITE_START) begin
            state_next = ST_USER;
          end else begin
            evIdIn     = (op_reg == OP_ID_ENTRY);
            evIdOut    = (op_reg == OP_ID_EXIT);
            rspv_next  = 1'b1;
            rspd_next  = '0;
            state_next = ST_IDLE;
          end
        end
      end
      ST_USER: begin
        start_next = 1'b1;
        ewr_next   = (op_reg == OP_WRITE_START) || (op_reg == OP_LOAD);
        eee_next   = ee_reg && (op_reg != OP_ID_READ);
        edata_next = data_reg;
        if (op_reg == OP_ID_READ) begin
          eaddr_next = {{(ADDR_W-1){1'b0}}, addr_reg[0]};
        end else if (op_reg == OP_POLL) begin
          eaddr_next = laddr_reg[ee_reg];
        end else begin
          eaddr_next = addr_reg;
        end
        state_next = ST_USER_WAIT;
      end
      ST_USER_WAIT: begin
        if (engDone) begin
          evLoad     = ewr_reg;
          evPoll     = (op_reg == OP_POLL);
          rspv_next  = 1'b1;
          rspd_next  = ewr_reg ? '0 : engRd;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    ready_next = (state_next == ST_IDLE) && !take;
  end

  // Window, busy and id mode
  always_comb begin
    open_next  = open_reg;
    lee_next   = lee_reg;
    ltim_next  = ltim_reg;
    busy_next  = busy_reg;
    lbit_next  = lbit_reg;
    id_next    = id_reg;
    for (int i = 0; i < 2; i++) begin
      btim_next[i]  = btim_reg[i];
      laddr_next[i] = laddr_reg[i];
      if (busy_reg[i]) begin
        btim_next[i] = btim_reg[i] + TW'(1);
        if (btim_reg[i] == WRITE_END) begin
          busy_next[i] = 1'b0;
        end
      end
    end
    if (open_reg) begin
      ltim_next = ltim_reg + TW'(1);
      if (ltim_reg == WINDOW_END) begin
        open_next          = 1'b0;
        busy_next[lee_reg] = 1'b1;
        btim_next[lee_reg] = '0;
      end
    end
    if (evPoll && (engRd[POLL_BIT] == lbit_reg[ee_reg])) begin
      busy_next[ee_reg] = 1'b0;
    end
    if (evLoad) begin
      open_next          = 1'b1;
      lee_next           = ee_reg;
      ltim_next          = '0;
      laddr_next[ee_reg] = eaddr_reg;
      lbit_next[ee_reg]  = edata_reg[POLL_BIT];
    end
    if (evIdIn) begin
      id_next = 1'b1;
    end
    if (evIdOut) begin
      id_next = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      seq_reg   <= 2'd0;
      op_reg    <= OP_READ;
      ee_reg    <= 1'b0;
      addr_reg  <= '0;
      data_reg  <= '0;
      ready_reg <= 1'b0;
      rspv_reg  <= 1'b0;
      rspd_reg  <= '0;
      rspe_reg  <= 1'b0;
      start_reg <= 1'b0;
      ewr_reg   <= 1'b0;
      eee_reg   <= 1'b0;
      eaddr_reg <= '0;
      edata_reg <= '0;
    end else begin
      state_reg <= state_next;
      seq_reg   <= seq_next;
      op_reg    <= op_next;
      ee_reg    <= ee_next;
      addr_reg  <= addr_next;
      data_reg  <= data_next;
      ready_reg <= ready_next;
      rspv_reg  <= rspv_next;
      rspd_reg  <= rspd_next;
      rspe_reg  <= rspe_next;
      start_reg <= start_next;
      ewr_reg   <= ewr_next;
      eee_reg   <= eee_next;
      eaddr_reg <= eaddr_next;
      edata_reg <= edata_next;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      open_reg  <= 1'b0;
      lee_reg   <= 1'b0;
      ltim_reg  <= '0;
      busy_reg  <= 2'b00;
      btim_reg  <= '{default: '0};
      laddr_reg <= '{default: '0};
      lbit_reg  <= 2'b00;
      id_reg    <= 1'b0;
    end else begin
      open_reg  <= open_next;
      lee_reg   <= lee_next;
      ltim_reg  <= ltim_next;
      busy_reg  <= busy_next;
      btim_reg  <= btim_next;
      laddr_reg <= laddr_next;
      lbit_reg  <= lbit_next;
      id_reg    <= id_next;
    end
  end

  bus_cycle pins (
    .clock         (clock),
    .srst          (srst),
    .start         (start_reg),
    .isWrite       (ewr_reg),
    .toEeprom      (eee_reg),
    .addrIn        (eaddr_reg),
    .dataIn        (edata_reg),
    .done          (engDone),
    .rdData        (engRd),
    .addrPins      (addrPins),
    .dataOut       (dataOut),
    .dataOe        (dataOe),
    .dataPinsIn    (dataIn),
    .flashSelectN  (flashSelectN),
    .eepromSelectN (eepromSelectN),
    .writeEnableN  (writeEnableN),
    .outputEnableN (outputEnableN)
  );

  assign cmdReady   = ready_reg;
  assign rspValid   = rspv_reg;
  assign rspData    = rspd_reg;
  assign rspError   = rspe_reg;
  assign flashBusy  = busy_reg[FLASH_IDX];
  assign eepromBusy = busy_reg[EEPROM_IDX];
  assign loadOpen   = open_reg;
  assign idMode     = id_reg;

endmodule : dual_array_host

// *** pkg/dual_array_pkg.sv ***
/*
  Constants for the flash and EEPROM host: widths, commands, timing counts.
  Assumes a 200 MHz clock and a device that times its own write cycles.
*/
// How it works
// - Every write start sends the three-byte write enable sequence first.
// - Host loads each next byte within 150 us of the previous one.
// - Flash reads are allowed between EEPROM byte loads inside the window.
// - Flash select and EEPROM select are never low together.
// - Identification reads use flash select, A0 chooses maker or part code.
// - Command bytes go on eight data lines, addresses on low fifteen.
package dual_array_pkg;

  localparam int          ADDR_W      = 19;
  localparam int          DATA_W      = 8;
  localparam int          CMD_ADDR_W  = 15;
  localparam int          POLL_BIT    = 7;

  localparam logic [14:0] CMD_ADDR_A  = 15'h5555;
  localparam logic [14:0] CMD_ADDR_B  = 15'h2AAA;
  localparam logic [7:0]  CMD_BYTE_A  = 8'hAA;
  localparam logic [7:0]  CMD_BYTE_B  = 8'h55;
  localparam logic [7:0]  CMD_WRITE   = 8'hA0;
  localparam logic [7:0]  CMD_ID_IN   = 8'h90;
  localparam logic [7:0]  CMD_ID_OUT  = 8'hF0;

  localparam int CLK_PERIOD_NS         = 5;
  localparam int STROBE_NS             = 100;
  localparam int HIGH_NS               = 100;
  localparam int ACCESS_NS             = 120;
  localparam int DATA_HOLD_NS          = 10;
  localparam int BYTE_LOAD_WINDOW_US   = 150;
  localparam int FLASH_WRITE_TIME_MS   = 10;

  localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HIGH_CYC      = (HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC    = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_HOLD_CYC = (DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WINDOW_CYC    = (BYTE_LOAD_WINDOW_US * 1000) / CLK_PERIOD_NS;
  localparam int WRITE_CYC     =
    (FLASH_WRITE_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOAD_MARGIN_CYC = 64;

  localparam int FLASH_IDX  = 0;
  localparam int EEPROM_IDX = 1;

  typedef enum logic [2:0] {
    OP_READ,
    OP_WRITE_START,
    OP_LOAD,
    OP_POLL,
    OP_ID_ENTRY,
    OP_ID_EXIT,
    OP_ID_READ
  } op_t;

endpackage : dual_array_pkg
